// ===== wsw_ctrl.sv
/*
 * Watchdog with shared postscaler, sleep entry and wake-up control.
 * Assumes the core pulses one-cycle commands on mclk_in and honours
 * the wake, vector and reset answers; pins sampled outside are held.
 */
// Chosen here: register access over APB.
module wsw_ctrl #(
    parameter int WDT_CYCLES = wsw_pkg::WDT_BASE_CYCLES,
    parameter int NUM_SRC    = 8,
    parameter int PIN_W      = 8
) (
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_in,
    input  wire logic                  master_clear_pin_in,
    // apb slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [15:0]           paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    // core commands and answers
    input  wsw_pkg::wsw_core_cmd_t     cmd_in,
    input  wire logic [15:0]           pc_in,
    input  wire logic                  global_irq_enable_in,
    input  wire logic [NUM_SRC-1:0]    irq_flag_in,
    input  wire logic [NUM_SRC-1:0]    irq_enable_in,
    output wsw_pkg::wsw_core_rsp_t     rsp_out,
    output logic      [15:0]           prefetch_pc_out,
    output logic      [15:0]           stack_push_out,
    output logic                       stack_push_en_out,
    // power and pins
    output logic                       osc_driver_en_out,
    input  wire logic [PIN_W-1:0]      pin_out_in,
    input  wire logic [PIN_W-1:0]      pin_oe_in,
    output logic      [PIN_W-1:0]      pin_out_out,
    output logic      [PIN_W-1:0]      pin_oe_out
);

    // ==========================================================
    // registers and state
    // ==========================================================
    logic [7:0]  option_control_r;
    logic [7:0]  configuration_fuses_r;
    logic        timeout_flag_r;
    logic        powerdown_flag_r;
    logic        cause_wdr_r;
    logic        sleeping_r;
    logic [31:0] watchdog_counter_r;
    logic [7:0]  postscale_r;
    logic [3:0]  rc_div_r;
    logic        rc_tick;
    logic        expire;
    logic        wdt_on;
    logic        irq_pend;
    logic [2:0]  master_clear_pin_sync_r;
    logic        master_clear_pin_r;
    logic        sleep_done;
    logic        apb_wr;
    logic [2:0]  ratio;

    function automatic logic [7:0] ratio_mask(input logic [2:0] r);
        ratio_mask = 8'(({1'b0, 8'h00} | 9'h001) << r) - 8'h01;
    endfunction : ratio_mask

    assign wdt_on   = configuration_fuses_r[wsw_pkg::WDTEN_BIT];
    assign irq_pend = |(irq_flag_in & irq_enable_in);
    assign ratio    = option_control_r[wsw_pkg::RATIO_LSB +: 3];
    assign apb_wr   = psel_in & penable_in & pwrite_in;
    assign sleep_done = cmd_in.sleep & ~sleeping_r & ~irq_pend;

    // ==========================================================
    // master clear pin synchroniser
    // ==========================================================
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            master_clear_pin_sync_r <= 3'h0;
            master_clear_pin_r      <= 1'b0;
        end
        else
        begin
            master_clear_pin_sync_r <= {master_clear_pin_sync_r[1:0], master_clear_pin_in};
            if (master_clear_pin_sync_r[2] == master_clear_pin_sync_r[1])
            begin
                master_clear_pin_r <= master_clear_pin_sync_r[2];
            end
        end
    end

    // ==========================================================
    // independent watchdog tick (never gated by sleep)
    // ==========================================================
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rc_div_r <= 4'h0;
        end
        else
        begin
            rc_div_r <= (rc_div_r == 4'(wsw_pkg::RC_DIV - 1)) ? 4'h0 : rc_div_r + 4'h1;
        end
    end
    assign rc_tick = (rc_div_r == 4'h0);

    // ==========================================================
    // watchdog counter and shared postscaler
    // ==========================================================
    logic base_wrap;
    assign base_wrap = rc_tick &&
        (watchdog_counter_r >= 32'(WDT_CYCLES / wsw_pkg::RC_DIV) - 32'h1);
    // no postscale when the prescaler belongs to the timer
    assign expire = wdt_on & base_wrap &
        (~option_control_r[wsw_pkg::PSA_BIT] | ((postscale_r & ratio_mask(ratio)) ==
         ratio_mask(ratio)));

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            watchdog_counter_r <= 32'h0;
            postscale_r        <= 8'h00;
        end
        else if (cmd_in.clear_wdt || sleep_done || expire || master_clear_pin_r)
        begin
            watchdog_counter_r <= 32'h0;
            if (option_control_r[wsw_pkg::PSA_BIT] || expire)
            begin
                postscale_r <= 8'h00;
            end
        end
        else if (wdt_on && rc_tick)
        begin
            if (base_wrap)
            begin
                watchdog_counter_r <= 32'h0;
                postscale_r        <= postscale_r + 8'h01;
            end
            else
            begin
                watchdog_counter_r <= watchdog_counter_r + 32'h1;
            end
        end
    end

    // ==========================================================
    // sleep state, flags and wake-up
    // ==========================================================
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sleeping_r       <= 1'b0;
            timeout_flag_r   <= 1'b1;
            powerdown_flag_r <= 1'b1;
            cause_wdr_r      <= 1'b0;
            rsp_out          <= '0;
            osc_driver_en_out <= 1'b1;
        end
        else
        begin
            rsp_out <= '0;
            if (master_clear_pin_r)
            begin
                sleeping_r        <= 1'b0;
                cause_wdr_r       <= 1'b0;
                osc_driver_en_out <= 1'b1;
            end
            else if (expire)
            begin
                timeout_flag_r <= 1'b0;
                if (sleeping_r)
                begin
                    sleeping_r        <= 1'b0;
                    osc_driver_en_out <= 1'b1;
                    rsp_out.wake      <= 1'b1;
                end
                else
                begin
                    cause_wdr_r       <= 1'b1;
                    rsp_out.wdt_reset <= 1'b1;
                end
            end
            else if (sleep_done)
            begin
                sleeping_r        <= 1'b1;
                powerdown_flag_r  <= 1'b0;
                timeout_flag_r    <= 1'b1;
                osc_driver_en_out <= 1'b0;
            end
            else if (sleeping_r && irq_pend)
            begin
                // sleep already fully taken effect before this wake
                sleeping_r          <= 1'b0;
                osc_driver_en_out   <= 1'b1;
                rsp_out.wake        <= 1'b1;
                rsp_out.wake_vector <= global_irq_enable_in;
                rsp_out.vector      <= global_irq_enable_in ? wsw_pkg::IRQ_VECTOR
                                                            : 16'h0000;
            end
        end
    end

    // ==========================================================
    // prefetch and interrupt entry stack push
    // ==========================================================
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prefetch_pc_out   <= 16'h0000;
            stack_push_out    <= 16'h0000;
            stack_push_en_out <= 1'b0;
        end
        else
        begin
            if (cmd_in.sleep)
            begin
                prefetch_pc_out <= pc_in + 16'h0001;
            end
            stack_push_en_out <= cmd_in.irq_entry;
            if (cmd_in.irq_entry)
            begin
                stack_push_out <= pc_in;
            end
        end
    end

    // ==========================================================
    // pin hold while asleep
    // ==========================================================
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_out_out <= '0;
            pin_oe_out  <= '0;
        end
        else if (!sleeping_r)
        begin
            pin_out_out <= pin_out_in;
            pin_oe_out  <= pin_oe_in;
        end
    end

    // ==========================================================
    // apb slave, zero wait states
    // ==========================================================
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            option_control_r      <= wsw_pkg::OPTION_RST;
            configuration_fuses_r <= wsw_pkg::CONFIG_RST;
        end
        else if (apb_wr)
        begin
            unique case (paddr_in)
                wsw_pkg::OPTION_OFS: option_control_r <= pwdata_in[7:0];
                // every write can only clear fuses; a fuse cleared stays cleared
                wsw_pkg::CONFIG_OFS: configuration_fuses_r <=
                    configuration_fuses_r & pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_out  <= 32'h0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
            if (psel_in && !penable_in)
            begin
                unique case (paddr_in)
                    wsw_pkg::OPTION_OFS:  prdata_out <= {24'h0, option_control_r};
                    wsw_pkg::CONFIG_OFS:  prdata_out <= {24'h0, configuration_fuses_r};
                    wsw_pkg::STATUS_OFS:  prdata_out <= {27'h0, timeout_flag_r,
                                                         powerdown_flag_r, 1'b0,
                                                         sleeping_r, cause_wdr_r};
                    wsw_pkg::COUNTER_OFS: prdata_out <= watchdog_counter_r;
                    default:              pslverr_out <= 1'b1;
                endcase
            end
        end
    end

endmodule : wsw_ctrl

// ===== wsw_pkg.sv
/*
 * Package for the watchdog, sleep and wake-up control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a single 50 MHz system clock and an APB register port.
 */
package wsw_pkg;

    // ==========================================================
    // register map: option and config by word index, byte address is four times the index; status, control and counter by byte address
    // ==========================================================
    localparam logic [13:0] OPTION_IDX      = 14'h0081;
    localparam logic [13:0] CONFIG_IDX      = 14'h2007;
    localparam logic [15:0] OPTION_OFS      = {OPTION_IDX, 2'h0};
    localparam logic [15:0] CONFIG_OFS      = {CONFIG_IDX, 2'h0};
    localparam logic [15:0] STATUS_OFS      = 16'h8020;
    localparam logic [15:0] CONTROL_OFS     = 16'h8024;
    localparam logic [15:0] COUNTER_OFS     = 16'h8028;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int PSA_BIT       = 3;
    localparam int RATIO_LSB     = 0;
    localparam int WDTEN_BIT     = 2;
    localparam int PD_BIT        = 3;
    localparam int TO_BIT        = 4;
    localparam int CAUSE_WDR_BIT = 0;
    localparam int SLEEPING_BIT  = 1;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] CONFIG_RST = 8'hFF;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int  CLK_HZ          = 50_000_000;
    localparam int  WDT_BASE_US     = 18_000;
    localparam int  WDT_BASE_CYCLES = CLK_HZ / 1_000_000 * WDT_BASE_US;
    localparam int  RC_DIV          = 16;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    // ==========================================================
    // types
    // ==========================================================
    typedef struct packed {
        logic clear_wdt;
        logic sleep;
        logic irq_entry;
    } wsw_core_cmd_t;

    typedef struct packed {
        logic        wake;
        logic        wake_vector;
        logic        wdt_reset;
        logic [15:0] vector;
    } wsw_core_rsp_t;

endpackage : wsw_pkg

// ===== wsw_ctrl_properties.sv
/* wsw_ctrl_properties: port-level checks on wsw_ctrl, attached by bind.
   Assumes core commands are one-cycle pulses and a single clock. */
module wsw_ctrl_properties #(
    parameter int NUM_SRC = 8,
    parameter int PIN_W   = 8
) (
    // clock, reset and apb
    input wire logic               mclk_in,
    input wire logic               rst_in,
    input wire logic               psel_in,
    input wire logic               penable_in,
    input wire logic               pready_out,
    // core side
    input wsw_pkg::wsw_core_cmd_t  cmd_in,
    input wire logic [15:0]        pc_in,
    input wire logic [NUM_SRC-1:0] irq_flag_in,
    input wire logic [NUM_SRC-1:0] irq_enable_in,
    input wsw_pkg::wsw_core_rsp_t  rsp_out,
    input wire logic [15:0]        prefetch_pc_out,
    // power and pins
    input wire logic               osc_driver_en_out,
    input wire logic [PIN_W-1:0]   pin_out_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // ========================================
    // helpers
    wire logic pend = |(irq_flag_in & irq_enable_in);
    sequence s_sleep_taken;
        cmd_in.sleep && osc_driver_en_out && !pend;
    endsequence
    // ========================================
    // properties
    chk_apb_answer: assert property (psel_in && !penable_in |=> pready_out)
        else $error("apb access not answered");
    chk_sleep_osc: assert property (s_sleep_taken |=> !osc_driver_en_out)
        else $error("oscillator not stopped by sleep");
    chk_sleep_nop: assert property (cmd_in.sleep && osc_driver_en_out && pend
        |=> osc_driver_en_out)
        else $error("sleep with pending interrupt not a nop");
    chk_prefetch_next: assert property (s_sleep_taken
        |=> prefetch_pc_out == $past(pc_in) + 16'h0001)
        else $error("prefetch address wrong");
    chk_irq_wake: assert property (!osc_driver_en_out && $rose(pend) |=> rsp_out.wake)
        else $error("enabled interrupt did not wake");
    chk_vector_addr: assert property (rsp_out.wake_vector
        |-> rsp_out.wake && rsp_out.vector == wsw_pkg::IRQ_VECTOR)
        else $error("wake vector wrong");
    chk_pins_frozen: assert property (!osc_driver_en_out && !$past(osc_driver_en_out)
        |-> $stable(pin_out_out))
        else $error("pins moved during sleep");
    chk_reset_awake: assert property (rsp_out.wdt_reset |-> $past(osc_driver_en_out))
        else $error("watchdog reset while asleep");
    chk_wake_asleep: assert property (rsp_out.wake |-> !$past(osc_driver_en_out))
        else $error("wake while running");
endmodule : wsw_ctrl_properties

bind wsw_ctrl wsw_ctrl_properties #(.NUM_SRC(NUM_SRC), .PIN_W(PIN_W)) wsw_ctrl_properties_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pready_out(pready_out), .cmd_in(cmd_in), .pc_in(pc_in), .irq_flag_in(irq_flag_in),
    .irq_enable_in(irq_enable_in), .rsp_out(rsp_out), .prefetch_pc_out(prefetch_pc_out),
    .osc_driver_en_out(osc_driver_en_out), .pin_out_out(pin_out_out));

// ===== wsw_core_model.sv
/* wsw_core_model: behavioural processor core in front of wsw_ctrl.
   Assumes the bench pulses sleep_req_in and sets the keepalive gap. */
module wsw_core_model (
    // clock, reset and bench requests
    input wire logic                mclk_in,
    input wire logic                rst_in,
    input wire logic                sleep_req_in,
    input wire logic [7:0]          gap_in,
    // answers and commands
    input wsw_pkg::wsw_core_rsp_t   rsp_in,
    output wsw_pkg::wsw_core_cmd_t  cmd_out,
    output logic [15:0]             pc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    // gap of zero stops the keepalive so the watchdog can run out
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_r   <= 8'h00;
            cmd_out <= '0;
            pc_out  <= 16'h0123;
        end
        else
        begin
            cnt_r <= (cnt_r >= gap_in) ? 8'h00 : cnt_r + 8'h01;
            cmd_out.clear_wdt <= (gap_in != 8'h00) && (cnt_r == gap_in);
            cmd_out.sleep     <= sleep_req_in;
            cmd_out.irq_entry <= rsp_in.wake_vector;
            // run the instruction after sleep, then vector once pushed
            if (rsp_in.wdt_reset)
                pc_out <= 16'h0000;
            else if (cmd_out.irq_entry)
                pc_out <= wsw_pkg::IRQ_VECTOR;
            else if (rsp_in.wake)
                pc_out <= pc_out + 16'h0001;
        end
    end
endmodule : wsw_core_model

// ===== testbench.sv
/* testbench: self-checking bench for wsw_ctrl with a core model.
   Assumes a 64-cycle watchdog and apb answers within a few cycles. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   mclk_in = 1'b0;
    logic                   rst_in = 1'b1;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic                   sleep_req = 1'b0;
    logic                   global_irq_enable = 1'b0;
    logic                   master_clear_pin = 1'b0;
    logic                   pready, pslverr, osc_en, push_en, hit;
    logic [15:0]            paddr = 16'h0000;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata, q;
    logic [7:0]             gap = 8'h00;
    logic [7:0]             flag = 8'h00;
    logic [7:0]             en = 8'h00;
    logic [7:0]             pin_in = 8'hA5;
    logic [7:0]             pin_q, oe_q;
    logic [15:0]            pc, pre_pc, push_pc;
    wsw_pkg::wsw_core_cmd_t cmd;
    wsw_pkg::wsw_core_rsp_t rsp, seen;
    int                     fail_count = 0;
    int                     compares = 0;

    always #10 mclk_in = ~mclk_in;

    wsw_ctrl #(.WDT_CYCLES(64)) wsw_ctrl_inst (
        .mclk_in(mclk_in), .rst_in(rst_in), .master_clear_pin_in(master_clear_pin), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cmd_in(cmd),
        .pc_in(pc), .global_irq_enable_in(global_irq_enable), .irq_flag_in(flag), .irq_enable_in(en),
        .rsp_out(rsp), .prefetch_pc_out(pre_pc), .stack_push_out(push_pc),
        .stack_push_en_out(push_en), .osc_driver_en_out(osc_en), .pin_out_in(pin_in),
        .pin_oe_in(~pin_in), .pin_out_out(pin_q), .pin_oe_out(oe_q));
    wsw_core_model wsw_core_model_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .sleep_req_in(sleep_req), .gap_in(gap), .rsp_in(rsp), .cmd_out(cmd), .pc_out(pc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // ========================================
    // apb master and waits
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge mclk_in);
        if (n == 20)
        begin
            fail_count++;
            final_report();
        end
        q = prdata;
        hit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_flags(input logic [1:0] exp);
        apb(1'b0, wsw_pkg::STATUS_OFS, 32'h0);
        chk({q[wsw_pkg::TO_BIT], q[wsw_pkg::PD_BIT]}, exp);
    endtask : chk_flags

    // watches one bit of the answer; a missed expected event ends the run
    task automatic wait_rsp(input int b, input int lim, input logic want);
        hit = 1'b0;
        for (int n = 0; n < lim && hit !== 1'b1; n++)
        begin
            @(posedge mclk_in);
            seen = rsp;
            hit = rsp[b];
        end
        chk(hit, want);
        if (want && hit !== 1'b1)
            final_report();
    endtask : wait_rsp

    task automatic do_sleep();
        @(posedge mclk_in);
        sleep_req <= 1'b1;
        @(posedge mclk_in);
        sleep_req <= 1'b0;
        repeat (3) @(posedge mclk_in);
    endtask : do_sleep

    // ========================================
    // scenarios
    task automatic t_regs();
        apb(1'b0, wsw_pkg::OPTION_OFS, 32'h0);
        chk(q, {24'h0, wsw_pkg::OPTION_RST});
        apb(1'b0, wsw_pkg::CONFIG_OFS, 32'h0);
        chk(q, {24'h0, wsw_pkg::CONFIG_RST});
        chk_flags(2'b11);
        chk(q[wsw_pkg::CAUSE_WDR_BIT], 1'b0);
        apb(1'b0, 16'h0300, 32'h0);
        chk(hit, 1'b1);
        apb(1'b1, wsw_pkg::OPTION_OFS, 32'h8);
        apb(1'b0, wsw_pkg::OPTION_OFS, 32'h0);
        chk(q, 32'h8);
    endtask : t_regs

    task automatic t_sleep_nop();
        flag <= 8'h01;
        en <= 8'h01;
        do_sleep();
        chk(osc_en, 1'b1);
        chk_flags(2'b11);
        flag <= 8'h00;
        en <= 8'h00;
    endtask : t_sleep_nop

    task automatic t_wdt_reset();
        gap <= 8'h14;
        wait_rsp(16, 3000, 1'b0);
        apb(1'b0, wsw_pkg::OPTION_OFS, 32'h0);
        chk(q, 32'h8);
        gap <= 8'h00;
        wait_rsp(16, 20000, 1'b1);
        chk_flags(2'b01);
        chk(q[wsw_pkg::CAUSE_WDR_BIT], 1'b1);
        // keepalive again so a repeated expiry cannot hit the next sleep
        gap <= 8'h14;
        apb(1'b1, wsw_pkg::OPTION_OFS, 32'h8);
    endtask : t_wdt_reset

    task automatic t_sleep_wdt();
        logic [7:0] held;
        apb(1'b1, wsw_pkg::OPTION_OFS, 32'h9);
        held = pin_q;
        do_sleep();
        gap <= 8'h00;
        chk(osc_en, 1'b0);
        chk(pre_pc, pc + 16'h0001);
        pin_in <= ~pin_in;
        chk_flags(2'b10);
        chk(pin_q, held);
        wait_rsp(18, 70, 1'b0);
        wait_rsp(18, 200, 1'b1);
        chk(seen.wdt_reset, 1'b0);
        chk_flags(2'b00);
    endtask : t_sleep_wdt

    task automatic t_irq_wake();
        gap <= 8'h14;
        for (int g = 0; g < 2; g++)
        begin
            global_irq_enable <= g[0];
            do_sleep();
            flag <= 8'h04;
            wait_rsp(18, 20, 1'b0);
            en <= 8'h04;
            wait_rsp(18, 20, 1'b1);
            chk(seen.wake_vector, g[0]);
            if (g == 1)
                chk(seen.vector, wsw_pkg::IRQ_VECTOR);
            chk_flags(2'b10);
            if (g == 1)
                chk(push_pc, pre_pc);
            flag <= 8'h00;
            en <= 8'h00;
        end
    endtask : t_irq_wake

    task automatic t_master_clear_pin();
        do_sleep();
        chk(osc_en, 1'b0);
        master_clear_pin <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk(osc_en, 1'b1);
        master_clear_pin <= 1'b0;
        repeat (6) @(posedge mclk_in);
        apb(1'b0, wsw_pkg::STATUS_OFS, 32'h0);
        chk(q[wsw_pkg::SLEEPING_BIT], 1'b0);
    endtask : t_master_clear_pin

    task automatic t_fuse_off();
        gap <= 8'h00;
        apb(1'b1, wsw_pkg::CONFIG_OFS, 32'hFB);
        apb(1'b0, wsw_pkg::CONFIG_OFS, 32'h0);
        chk(q, 32'hFB);
        wait_rsp(16, 3000, 1'b0);
        do_sleep();
        wait_rsp(18, 3000, 1'b0);
    endtask : t_fuse_off

    initial
    begin
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_regs();
        t_sleep_nop();
        t_wdt_reset();
        t_sleep_wdt();
        t_irq_wake();
        t_master_clear_pin();
        t_fuse_off();
        final_report();
    end
endmodule : testbench
